// ### design/rcfg_consts.vh
// Constants for the receive input sync and configuration block
`ifndef RCFG_CONSTS_VH
`define RCFG_CONSTS_VH
// ===========================================================
// Register indices (byte address is four times the index)
`define RCFG_IDX_CNT_LSB 5'h00
`define RCFG_IDX_CNT_MSB 5'h01
`define RCFG_IDX_CNT_SSEL 5'h02
`define RCFG_IDX_BLK_SSEL 5'h03
`define RCFG_IDX_CFG_A 5'h04
`define RCFG_IDX_FMT 5'h05
`define RCFG_IDX_NZ_MASK 5'h06
`define RCFG_IDX_ONESHOT 5'h07
`define RCFG_IDX_TEST_CTRL 5'h08
`define RCFG_IDX_CONST 5'h09
`define RCFG_IDX_STATUS 5'h0A
// ===========================================================
// Reset values and LFSR taps
`define RCFG_RST16 16'h0000
`define RCFG_LFSR_SEED 16'hACE1
`define RCFG_LFSR_TAPS 16'hB400
// ===========================================================
// counter_sync_select fields
`define RCFG_B_SWAP_AB 15
`define RCFG_B_SWAP_CD 14
`define RCFG_F_CNT_SSEL 10:8
`define RCFG_F_CNT_WIDTH 7:0
// block_sync_select fields
`define RCFG_F_FIFO_SSEL 14:12
`define RCFG_F_TST_SSEL 10:8
`define RCFG_F_OUT_SSEL 6:4
`define RCFG_F_DDC_SSEL 2:0
// input_config_a fields
`define RCFG_F_RATE 15:14
`define RCFG_B_STRAP_AB 13
`define RCFG_B_STRAP_CD 12
`define RCFG_B_CONST_ENA 11
`define RCFG_B_BYPASS 10
`define RCFG_B_RAM_READ 9
`define RCFG_F_TST_DELAY 7:4
`define RCFG_F_METER_IQ 3:0
// one-shot and test control bits
`define RCFG_B_ONESHOT 7
`define RCFG_B_SELF_TEST 0
`define RCFG_B_NOISE_SENSE 1
// ===========================================================
// Sync source codes
`define RCFG_SRC_COUNTER 3'b100
`define RCFG_SRC_ONESHOT 3'b101
`define RCFG_SRC_ZERO 3'b110
`define RCFG_SRC_ONE 3'b111
// Rate codes
`define RCFG_RATE_DIV2 2'b01
`define RCFG_RATE_DIV4 2'b10
`define RCFG_RATE_DIV8 2'b11
// Bus responses
`define RCFG_RESP_OKAY 2'b00
`define RCFG_RESP_SLVERR 2'b10
`endif

// ### design/rcfg_lane.v
// One input lane: MSB alignment, format conversion and noise bits
`default_nettype none
module rcfg_lane (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] raw,
	input wire [2:0] msb_pos,
	input wire twos_fmt,
	input wire [15:0] noise,
	input wire noise_ena,
	output reg [15:0] sample
);
	reg [15:0] aligned;

	// ===========================================================
	// Alignment and conversion
	always @* begin
		aligned = raw << msb_pos;
		if (!twos_fmt) begin
			aligned[15] = ~aligned[15];
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sample <= 16'h0000;
		end else begin
			sample <= aligned + (noise_ena ? noise : 16'h0000);
		end
	end
endmodule // rcfg_lane
`default_nettype wire

// ### design/rcfg_top.v
// Receive input sync routing and configuration register bank
`include "rcfg_consts.vh"
`default_nettype none
// Summary of operation
// - Swap bits route ports c/d onto a/b and a/b onto c/d
// - Sync code decode: pins, counter, one-shot, 0, 1
// - Counter pulse width 1 to 256 cycles
// - FIFO sync resets read and write pointers
// - Test decimator has its own sync selector
// - Channel sync drives sample clock generation
// - Rate field divides receive clock 1/2/4/8
// - Strapped pair write pointers follow lower input
// - Self-test plus const enable outputs constant
// - Bypass clocks samples directly; sync places strobe
// - Delay field sets decimator sample moment
// - Meters use complex pair or single input
// - MSB position field aligns each input
// - Format bit clear converts offset binary
// - Noise mask selects noise bits added
// - 32-bit interval counter, loaded interval minus one
// - One-shot fires on write 0 then 1
module rcfg_top (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire external_sync_pin_a,
	input wire external_sync_pin_b,
	input wire external_sync_pin_c,
	input wire external_sync_pin_d,
	input wire [15:0] rxin_a,
	input wire [15:0] rxin_b,
	input wire [15:0] rxin_c,
	input wire [15:0] rxin_d,
	input wire [3:0] rxin_valid,
	output wire [63:0] lane_data,
	output reg ddc_sample_strobe,
	output reg ddc_sync,
	output reg [11:0] fifo_wr_ptr,
	output reg [2:0] fifo_rd_ptr,
	output reg tst_decim_sample,
	output reg [15:0] test_gen_data,
	output reg test_gen_const_mode,
	output reg [63:0] meter_i_data,
	output reg [63:0] meter_q_data,
	output reg [3:0] meter_complex_select,
	output reg gain_ram_read_enable,
	output reg fifo_bypass,
	output reg sync_out
);
	// ===========================================================
	// Functions
	function sync_src;
		input [2:0] code;
		input [3:0] ext;
		input cnt_pulse;
		input one_shot;
		begin
			case (code)
			3'b000: sync_src = ext[0];
			3'b001: sync_src = ext[1];
			3'b010: sync_src = ext[2];
			3'b011: sync_src = ext[3];
			`RCFG_SRC_COUNTER: sync_src = cnt_pulse;
			`RCFG_SRC_ONESHOT: sync_src = one_shot;
			`RCFG_SRC_ZERO: sync_src = 1'b0;
			`RCFG_SRC_ONE: sync_src = 1'b1;
			default: sync_src = 1'b0;
			endcase
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16 = old;
			if (strb[0]) begin
				merge16[7:0] = data[7:0];
			end
			if (strb[1]) begin
				merge16[15:8] = data[15:8];
			end
		end
	endfunction

	function [2:0] rate_mask;
		input [1:0] rate;
		begin
			case (rate)
			`RCFG_RATE_DIV2: rate_mask = 3'h1;
			`RCFG_RATE_DIV4: rate_mask = 3'h3;
			`RCFG_RATE_DIV8: rate_mask = 3'h7;
			default: rate_mask = 3'h0;
			endcase
		end
	endfunction

	// ===========================================================
	// Registers
	reg [15:0] cnt_lsb;
	reg [15:0] cnt_msb;
	reg [15:0] cnt_ssel;
	reg [15:0] blk_ssel;
	reg [15:0] cfg_a;
	reg [15:0] fmt_cfg;
	reg [15:0] noise_bit_select;
	reg oneshot_bit;
	reg oneshot_pulse;
	reg [1:0] test_ctrl;
	reg [15:0] const_val;
	reg aw_held;
	reg w_held;
	reg [4:0] aw_idx;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg next_aw_held;
	reg next_w_held;
	reg next_bvalid;
	reg next_rvalid;
	reg [31:0] rd_word;
	reg rd_ok;
	wire do_wr;
	wire [4:0] ar_idx;

	assign do_wr = aw_held && w_held && !s_axi_bvalid;
	assign ar_idx = s_axi_araddr[6:2];

	// ===========================================================
	// Bus handshake
	always @* begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_bvalid = s_axi_bvalid;
		next_rvalid = s_axi_rvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
		end
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RCFG_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RCFG_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_bvalid <= next_bvalid;
			s_axi_rvalid <= next_rvalid;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx <= s_axi_awaddr[6:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bresp <= (aw_idx <= `RCFG_IDX_STATUS) ?
					`RCFG_RESP_OKAY : `RCFG_RESP_SLVERR;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? `RCFG_RESP_OKAY : `RCFG_RESP_SLVERR;
			end
		end
	end

	// ===========================================================
	// Register writes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_lsb <= `RCFG_RST16;
			cnt_msb <= `RCFG_RST16;
			cnt_ssel <= `RCFG_RST16;
			blk_ssel <= `RCFG_RST16;
			cfg_a <= `RCFG_RST16;
			fmt_cfg <= `RCFG_RST16;
			noise_bit_select <= `RCFG_RST16;
			oneshot_bit <= 1'b0;
			oneshot_pulse <= 1'b0;
			test_ctrl <= 2'b00;
			const_val <= `RCFG_RST16;
		end else begin
			oneshot_pulse <= 1'b0;
			if (do_wr) begin
				case (aw_idx)
				`RCFG_IDX_CNT_LSB: cnt_lsb <= merge16(cnt_lsb, w_data, w_strb);
				`RCFG_IDX_CNT_MSB: cnt_msb <= merge16(cnt_msb, w_data, w_strb);
				`RCFG_IDX_CNT_SSEL:
					cnt_ssel <= merge16(cnt_ssel, w_data, w_strb);
				`RCFG_IDX_BLK_SSEL:
					blk_ssel <= merge16(blk_ssel, w_data, w_strb);
				`RCFG_IDX_CFG_A: cfg_a <= merge16(cfg_a, w_data, w_strb);
				`RCFG_IDX_FMT: fmt_cfg <= merge16(fmt_cfg, w_data, w_strb);
				`RCFG_IDX_NZ_MASK:
					noise_bit_select <= merge16(noise_bit_select, w_data, w_strb);
				`RCFG_IDX_ONESHOT: begin
					if (w_strb[0]) begin
						oneshot_bit <= w_data[`RCFG_B_ONESHOT];
						oneshot_pulse <= w_data[`RCFG_B_ONESHOT] &&
							!oneshot_bit;
					end
				end
				`RCFG_IDX_TEST_CTRL: begin
					if (w_strb[0]) begin
						test_ctrl <= w_data[1:0];
					end
				end
				`RCFG_IDX_CONST: const_val <= merge16(const_val, w_data, w_strb);
				default: ;
				endcase
			end
		end
	end

	// ===========================================================
	// External sync pins
	reg [3:0] pin_s1;
	reg [3:0] pin_s2;
	reg [3:0] pin_s3;
	reg [3:0] ext_lvl;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
			ext_lvl <= 4'h0;
		end else begin
			pin_s1 <= {external_sync_pin_d, external_sync_pin_c,
				external_sync_pin_b, external_sync_pin_a};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			ext_lvl <= (pin_s2 & pin_s3) | (ext_lvl & (pin_s2 | pin_s3));
		end
	end

	// ===========================================================
	// Sync selectors: counter, fifo, test, channel, pin out
	reg cnt_pulse;
	reg [4:0] sel_prev;
	wire [4:0] sel_lvl;
	wire [4:0] sel_ev;

	assign sel_lvl[0] = sync_src(cnt_ssel[`RCFG_F_CNT_SSEL], ext_lvl,
		cnt_pulse, oneshot_pulse);
	assign sel_lvl[1] = sync_src(blk_ssel[`RCFG_F_FIFO_SSEL], ext_lvl,
		cnt_pulse, oneshot_pulse);
	assign sel_lvl[2] = sync_src(blk_ssel[`RCFG_F_TST_SSEL], ext_lvl,
		cnt_pulse, oneshot_pulse);
	assign sel_lvl[3] = sync_src(blk_ssel[`RCFG_F_DDC_SSEL], ext_lvl,
		cnt_pulse, oneshot_pulse);
	assign sel_lvl[4] = sync_src(blk_ssel[`RCFG_F_OUT_SSEL], ext_lvl,
		cnt_pulse, oneshot_pulse);
	assign sel_ev = sel_lvl & ~sel_prev;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sel_prev <= 5'h00;
			sync_out <= 1'b0;
			ddc_sync <= 1'b0;
		end else begin
			sel_prev <= sel_lvl;
			sync_out <= sel_lvl[4];
			ddc_sync <= sel_ev[3];
		end
	end

	// ===========================================================
	// Interval counter and pulse
	reg [31:0] interval_cnt;
	reg [7:0] pulse_left;
	wire cnt_wrap;

	assign cnt_wrap = interval_cnt == {cnt_msb, cnt_lsb};

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			interval_cnt <= 32'h00000000;
			cnt_pulse <= 1'b0;
			pulse_left <= 8'h00;
		end else begin
			if (sel_ev[0] || cnt_wrap) begin
				interval_cnt <= 32'h00000000;
			end else begin
				interval_cnt <= interval_cnt + 32'h00000001;
			end
			if (cnt_wrap) begin
				cnt_pulse <= 1'b1;
				pulse_left <= cnt_ssel[`RCFG_F_CNT_WIDTH];
			end else if (pulse_left != 8'h00) begin
				pulse_left <= pulse_left - 8'h01;
			end else begin
				cnt_pulse <= 1'b0;
			end
		end
	end

	// ===========================================================
	// Sample rate strobe and FIFO pointers
	reg [2:0] rate_div;
	wire rate_tick;
	wire [2:0] wp0;
	wire [2:0] wp2;

	assign rate_tick = (rate_div & rate_mask(cfg_a[`RCFG_F_RATE])) ==
		3'h0;
	assign wp0 = fifo_wr_ptr[2:0] + {2'b00, rxin_valid[0]};
	assign wp2 = fifo_wr_ptr[8:6] + {2'b00, rxin_valid[2]};

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate_div <= 3'h0;
			ddc_sample_strobe <= 1'b0;
			fifo_wr_ptr <= 12'h000;
			fifo_rd_ptr <= 3'h0;
		end else begin
			if (sel_ev[3]) begin
				rate_div <= 3'h0;
			end else begin
				rate_div <= rate_div + 3'h1;
			end
			ddc_sample_strobe <= rate_tick && !sel_ev[3];
			if (sel_ev[1] || cfg_a[`RCFG_B_BYPASS]) begin
				fifo_wr_ptr <= 12'h000;
				fifo_rd_ptr <= 3'h0;
			end else begin
				fifo_wr_ptr[2:0] <= wp0;
				fifo_wr_ptr[5:3] <= cfg_a[`RCFG_B_STRAP_AB] ? wp0 :
					fifo_wr_ptr[5:3] + {2'b00, rxin_valid[1]};
				fifo_wr_ptr[8:6] <= wp2;
				fifo_wr_ptr[11:9] <= cfg_a[`RCFG_B_STRAP_CD] ? wp2 :
					fifo_wr_ptr[11:9] + {2'b00, rxin_valid[3]};
				fifo_rd_ptr <= fifo_rd_ptr + {2'b00, rate_tick};
			end
		end
	end

	// ===========================================================
	// Test decimator timing
	reg decim_armed;
	reg [3:0] decim_cnt;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			decim_armed <= 1'b0;
			decim_cnt <= 4'h0;
			tst_decim_sample <= 1'b0;
		end else begin
			tst_decim_sample <= 1'b0;
			if (sel_ev[2]) begin
				decim_armed <= 1'b1;
				decim_cnt <= 4'h0;
			end else if (decim_armed) begin
				if (decim_cnt == cfg_a[`RCFG_F_TST_DELAY]) begin
					tst_decim_sample <= 1'b1;
					decim_armed <= 1'b0;
				end else begin
					decim_cnt <= decim_cnt + 4'h1;
				end
			end
		end
	end

	// ===========================================================
	// Test and noise generator
	reg [15:0] lfsr;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lfsr <= `RCFG_LFSR_SEED;
			test_gen_data <= 16'h0000;
			test_gen_const_mode <= 1'b0;
		end else begin
			lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `RCFG_LFSR_TAPS : 16'h0000);
			test_gen_const_mode <= test_ctrl[`RCFG_B_SELF_TEST] &&
				cfg_a[`RCFG_B_CONST_ENA];
			test_gen_data <= (test_ctrl[`RCFG_B_SELF_TEST] &&
				cfg_a[`RCFG_B_CONST_ENA]) ? const_val : lfsr;
		end
	end

	// ===========================================================
	// Input lanes
	wire [63:0] raw_bus;

	assign raw_bus[15:0] = cnt_ssel[`RCFG_B_SWAP_AB] ? rxin_c : rxin_a;
	assign raw_bus[31:16] = cnt_ssel[`RCFG_B_SWAP_AB] ? rxin_d : rxin_b;
	assign raw_bus[47:32] = cnt_ssel[`RCFG_B_SWAP_CD] ? rxin_a : rxin_c;
	assign raw_bus[63:48] = cnt_ssel[`RCFG_B_SWAP_CD] ? rxin_b : rxin_d;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			rcfg_lane u_lane (
				.clk_sys(clk_sys),
				.rst(rst),
				.raw(raw_bus[gi*16+15:gi*16]),
				.msb_pos(fmt_cfg[gi*4+3:gi*4+1]),
				.twos_fmt(fmt_cfg[gi*4]),
				.noise(lfsr & noise_bit_select),
				.noise_ena(test_ctrl[`RCFG_B_NOISE_SENSE]),
				.sample(lane_data[gi*16+15:gi*16])
			);
		end
	endgenerate

	// ===========================================================
	// Power meter inputs and plain control outputs
	integer mi;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meter_i_data <= 64'h0000000000000000;
			meter_q_data <= 64'h0000000000000000;
			meter_complex_select <= 4'h0;
			gain_ram_read_enable <= 1'b0;
			fifo_bypass <= 1'b0;
		end else begin
			meter_complex_select <= cfg_a[`RCFG_F_METER_IQ];
			gain_ram_read_enable <= cfg_a[`RCFG_B_RAM_READ];
			fifo_bypass <= cfg_a[`RCFG_B_BYPASS];
			for (mi = 0; mi < 4; mi = mi + 1) begin
				if (cfg_a[mi]) begin
					meter_i_data[mi*16 +: 16] <= lane_data[(mi/2)*32 +: 16];
					meter_q_data[mi*16 +: 16] <=
						lane_data[(mi/2)*32+16 +: 16];
				end else begin
					meter_i_data[mi*16 +: 16] <= lane_data[mi*16 +: 16];
					meter_q_data[mi*16 +: 16] <= 16'h0000;
				end
			end
		end
	end

	// ===========================================================
	// Read decode
	always @* begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (ar_idx)
		`RCFG_IDX_CNT_LSB: rd_word[15:0] = cnt_lsb;
		`RCFG_IDX_CNT_MSB: rd_word[15:0] = cnt_msb;
		`RCFG_IDX_CNT_SSEL: rd_word[15:0] = cnt_ssel;
		`RCFG_IDX_BLK_SSEL: rd_word[15:0] = blk_ssel;
		`RCFG_IDX_CFG_A: rd_word[15:0] = cfg_a;
		`RCFG_IDX_FMT: rd_word[15:0] = fmt_cfg;
		`RCFG_IDX_NZ_MASK: rd_word[15:0] = noise_bit_select;
		`RCFG_IDX_ONESHOT: rd_word[`RCFG_B_ONESHOT] = oneshot_bit;
		`RCFG_IDX_TEST_CTRL: rd_word[1:0] = test_ctrl;
		`RCFG_IDX_CONST: rd_word[15:0] = const_val;
		`RCFG_IDX_STATUS: rd_word[15:0] = {4'h0, rate_div, decim_armed,
			ext_lvl, cnt_pulse, fifo_rd_ptr};
		default: rd_ok = 1'b0;
		endcase
	end
endmodule // rcfg_top
`default_nettype wire

// ### tb/rcfg_properties.sv
// Port checker for the receive sync and configuration block
`default_nettype none
module rcfg_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ddc_sync,
	input wire logic tst_decim_sample,
	input wire logic fifo_bypass,
	input wire logic [11:0] fifo_wr_ptr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// Bus steps
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_b_answer;
		s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer)
		else $error("write response late");
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stands: assert property (p_b_stands)
		else $error("write response dropped");
	property p_r_answer;
		s_rd_taken |=> s_axi_rvalid && !s_axi_arready
			&& s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read answer wrong");
	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stands: assert property (p_r_stands)
		else $error("read data dropped");
	property p_w_refused;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_refused: assert property (p_w_refused)
		else $error("write taken while busy");
	// ==========================================================
	// Sync and pointers
	property p_bypass_ptr;
		fifo_bypass [*3] |-> fifo_wr_ptr == 12'h000;
	endproperty
	a_bypass_ptr: assert property (p_bypass_ptr)
		else $error("pointer moved in bypass");
	property p_ddc_pulse;
		ddc_sync |=> !ddc_sync;
	endproperty
	a_ddc_pulse: assert property (p_ddc_pulse)
		else $error("channel sync too long");
	property p_decim_pulse;
		tst_decim_sample |=> !tst_decim_sample;
	endproperty
	a_decim_pulse: assert property (p_decim_pulse)
		else $error("decimator sample too long");
endmodule // rcfg_checker
bind rcfg_top rcfg_checker u_chk (.*);
`default_nettype wire

// ### tb/rcfg_adc_model.sv
// Converter-side model: sample words, write strobes and sync pins
`default_nettype none
module rcfg_adc_model (
	input wire logic clk_sys,
	input wire logic [15:0] word,
	input wire logic [3:0] vld,
	input wire logic [3:0] pins,
	output var logic [15:0] rxin_a = 16'h0000,
	output var logic [15:0] rxin_b = 16'h0000,
	output var logic [15:0] rxin_c = 16'h0000,
	output var logic [15:0] rxin_d = 16'h0000,
	output var logic [3:0] rxin_valid = 4'h0,
	output var logic external_sync_pin_a = 1'b0,
	output var logic external_sync_pin_b = 1'b0,
	output var logic external_sync_pin_c = 1'b0,
	output var logic external_sync_pin_d = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lanes b to d offset the word so that routing faults show
	always @(posedge clk_sys) begin
		rxin_a <= word;
		rxin_b <= word ^ 16'h1000;
		rxin_c <= word ^ 16'h2000;
		rxin_d <= word ^ 16'h3000;
		rxin_valid <= vld;
		external_sync_pin_a <= pins[0];
		external_sync_pin_b <= pins[1];
		external_sync_pin_c <= pins[2];
		external_sync_pin_d <= pins[3];
	end
endmodule // rcfg_adc_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the receive sync and configuration block
`include "rcfg_consts.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [15:0] word = 16'h0123;
	logic [3:0] vld = 4'h0;
	logic [3:0] pins = 4'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, ddc_sample_strobe, ddc_sync, tst_decim_sample;
	wire test_gen_const_mode, sync_out;
	wire external_sync_pin_a, external_sync_pin_b;
	wire external_sync_pin_c, external_sync_pin_d;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] rxin_a, rxin_b, rxin_c, rxin_d, test_gen_data;
	wire [3:0] rxin_valid, meter_complex_select;
	wire [63:0] lane_data, meter_i_data, meter_q_data;
	wire [11:0] fifo_wr_ptr;
	int miscompares = 0;
	int num_checks = 0;
	int seed = 55;
	int so_cnt, st_cnt, i, k;
	logic cnt_on = 1'b0;
	time t_sync, t_dec;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [15:0] v;
	logic [15:0] fmt_v[4] = '{16'h0100, 16'h0000, 16'h0500, 16'h0400};
	logic [15:0] fmt_e[4] = '{16'h2123, 16'hA123, 16'h848C, 16'h048C};

	rcfg_top u_dut (.*, .fifo_rd_ptr(), .gain_ram_read_enable(),
		.fifo_bypass());
	rcfg_adc_model u_adc (.*);

	always #2.5 clk_sys = ~clk_sys;

	// ==========================================================
	// Checking and reporting
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic tmo;
		miscompares++;
		$display("ERROR %0t wait timed out", $time);
		report_and_stop;
	endtask
	always @(posedge clk_sys) begin
		if (cnt_on) begin
			so_cnt += sync_out;
			st_cnt += ddc_sample_strobe;
		end
		if (ddc_sync)
			t_sync = $time;
		if (tst_decim_sample)
			t_dec = $time;
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata} === exp_r.pop_front(), "read");
		if (s_axi_bvalid && s_axi_bready)
			chk(s_axi_bresp === exp_b.pop_front(), "write response");
	end

	// ==========================================================
	// Bus master and counting window
	task automatic wr(input logic [4:0] a, input logic [15:0] d,
		input logic [1:0] e = `RCFG_RESP_OKAY);
		int n;
		@(posedge clk_sys);
		exp_b.push_back(e);
		s_axi_awaddr <= {1'b0, a, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
		s_axi_bready <= 1'b0;
		if (n >= 60)
			tmo;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] d,
		input logic [1:0] e = `RCFG_RESP_OKAY);
		int n;
		@(posedge clk_sys);
		exp_r.push_back({e, 16'h0000, d});
		s_axi_araddr <= {1'b0, a, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
		s_axi_rready <= 1'b0;
		if (n >= 60)
			tmo;
	endtask
	task automatic win(input int s, input int n);
		repeat (s) @(posedge clk_sys);
		@(negedge clk_sys);
		so_cnt = 0;
		st_cnt = 0;
		cnt_on = 1'b1;
		repeat (n) @(negedge clk_sys);
		cnt_on = 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 2; i <= 6; i++) begin
			v = 16'($random(seed));
			v = v & (i == 4 ? 16'hFDFF : i == 5 ? 16'hFFEE : 16'hFFFF);
			rd(5'(i), 16'h0000);
			wr(5'(i), v);
			rd(5'(i), v);
		end
		wr(5'h1F, 16'h1234, `RCFG_RESP_SLVERR);
		rd(5'h1F, 16'h0000, `RCFG_RESP_SLVERR);
		$display("test registers done");
		wr(5'h02, 16'h0600);
		for (k = 0; k < 2; k++) begin
			pins <= k ? 4'h9 : 4'h6;
			for (i = 0; i < 8; i++) begin
				if (i == 4 || i == 5)
					continue;
				wr(5'h03, 16'(i << 4));
				win(8, 4);
				chk(so_cnt === ((i < 4 ? pins[i] : i[0]) ? 4 : 0), "source");
			end
		end
		pins <= 4'h0;
		wr(5'h03, 16'h0040);
		for (k = 0; k < 3; k++) begin
			wr(5'h00, k < 2 ? 16'd9 : 16'd511);
			wr(5'h02, k == 0 ? 16'h0600 : k == 1 ? 16'h0602 : 16'h06FF);
			// Long interval: let the first wrap pass before counting
			win(k < 2 ? 8 : 520, k < 2 ? 100 : 1024);
			chk(so_cnt === (k == 0 ? 10 : k == 1 ? 30 : 512), "width");
		end
		wr(5'h03, 16'h0050);
		for (k = 0; k < 4; k++) begin
			fork
				wr(5'h07, k == 2 ? 16'h0000 : 16'h0080);
				win(0, 20);
			join
			chk(so_cnt === ((k == 0 || k == 3) ? 1 : 0), "one-shot");
		end
		$display("test sync sources done");
		for (k = 0; k < 4; k++) begin
			wr(5'h04, 16'(k << 14));
			win(8, 64);
			chk(st_cnt === (64 >> k), "rate");
		end
		wr(5'h03, 16'h6303);
		for (k = 0; k < 2; k++) begin
			wr(5'h04, k ? 16'h00F0 : 16'h0000);
			pins <= 4'h8;
			repeat (30) @(posedge clk_sys);
			pins <= 4'h0;
			chk(t_dec - t_sync === (k ? 80 : 5), "decimator");
		end
		$display("test rate and decimator done");
		wr(5'h03, 16'h1000);
		for (k = 0; k < 3; k++) begin
			wr(5'h04, k == 0 ? 16'h0000 : k == 1 ? 16'h2000 : 16'h0400);
			pins <= 4'h2;
			repeat (8) @(posedge clk_sys);
			pins <= 4'h0;
			repeat (8) @(posedge clk_sys);
			chk(fifo_wr_ptr === 12'h000, "sync pointer");
			vld <= k == 2 ? 4'hF : 4'h1;
			repeat (3) @(posedge clk_sys);
			vld <= 4'h0;
			repeat (4) @(posedge clk_sys);
			v = k == 0 ? 16'h0003 : k == 1 ? 16'h001B : 16'h0000;
			chk(fifo_wr_ptr === v[11:0], "pointer");
		end
		$display("test fifo pointers done");
		for (k = 0; k < 4; k++) begin
			wr(5'h05, fmt_v[k]);
			repeat (4) @(posedge clk_sys);
			chk(lane_data[47:32] === fmt_e[k], "format");
		end
		wr(5'h05, 16'h0000);
		for (k = 0; k < 2; k++) begin
			wr(5'h02, k ? 16'h4000 : 16'h8000);
			repeat (4) @(posedge clk_sys);
			v = k ? 16'h8123 : 16'hA123;
			chk({lane_data[47:32], lane_data[15:0]} === {v, v}, "swap");
		end
		wr(5'h08, 16'h0001);
		wr(5'h09, 16'h5A5A);
		wr(5'h04, 16'h0805);
		repeat (4) @(posedge clk_sys);
		chk({test_gen_const_mode, test_gen_data} === 17'h15A5A, "const");
		chk(meter_complex_select === 4'h5, "meter select");
		chk(meter_i_data === 64'h9123812391238123, "meter i");
		chk(meter_q_data === 64'h0000912300009123, "meter q");
		wr(5'h06, 16'h8000);
		wr(5'h08, 16'h0002);
		k = 0;
		repeat (16) begin
			@(negedge clk_sys);
			k += lane_data[15];
			chk(lane_data[14:0] === 15'h0123, "noise low bits");
		end
		chk(k > 0 && k < 16, "noise bit");
		$display("test lanes and test generator done");
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
